// File: verilog/heater_current_alarm_monitor.sv
// Heater open, short and overcurrent alarm monitor, two sense channels
// Overview of operation
// [RQ1] Open and overcurrent checks use samples taken only while heating output is on.
// [RQ2] Short check uses samples taken only while heating output is off.
// [RQ3] Cooling output never feeds any heater current check.
// [RQ4] Open alarm on when on-interval current is below open threshold.
// [RQ5] Short alarm on when off-interval leakage is above short threshold.
// [RQ6] Overcurrent alarm on when on-interval current exceeds overcurrent threshold.
// [RQ7] On intervals of 100 ms or less skip open and overcurrent checks.
// [RQ8] Off intervals of 100 ms or less skip the short check.
// [RQ9] First alarm output is ordinary alarm ORed with all heater alarms.
// [RQ10] Control output passes through untouched whatever the alarms.
// [RQ11] Thresholds work from 0.1 to 49.9 A; 0.0 and 50.0 force.
// [RQ12] Threshold 0.0 holds open alarm off, short and overcurrent on.
// [RQ13] Threshold 50.0 holds open alarm on, short and overcurrent off.
// [RQ14] Current above 55.0 A reads as FFFF on the monitor.
// [RQ15] Heater and leakage current monitors readable per channel.
// [RQ16] Both sense channels are checked independently.
// [RQ17] Absent heater power gives open alarm after on intervals.
// [RQ18] Each alarm re-evaluated once per qualifying interval, held between.
`timescale 1ns/10ps
`default_nettype none
`include "heater_alarm_params.svh"
module heater_current_alarm_monitor (
  // Clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  NRST,
  // Control outputs
  input  wire logic                  HEAT_CTRL,
  input  wire logic                  COOL_CTRL,
  output var  logic                  SOLID_STATE_SWITCH,
  output var  logic                  COOL_OUT,
  // Current samples, tenths of an ampere
  input  wire heater_alarm_pkg::current_t CURRENT_SENSE_ONE,
  input  wire heater_alarm_pkg::current_t CURRENT_SENSE_TWO,
  // Thresholds, tenths of an ampere
  input  wire heater_alarm_pkg::current_t OPEN_THR_ONE,
  input  wire heater_alarm_pkg::current_t OPEN_THR_TWO,
  input  wire heater_alarm_pkg::current_t SHORT_THR_ONE,
  input  wire heater_alarm_pkg::current_t SHORT_THR_TWO,
  input  wire heater_alarm_pkg::current_t OVER_THR_ONE,
  input  wire heater_alarm_pkg::current_t OVER_THR_TWO,
  // Ordinary first alarm function
  input  wire logic                  BASE_ALARM,
  // Monitors
  output var  heater_alarm_pkg::current_t HEATER_CURRENT_ONE,
  output var  heater_alarm_pkg::current_t HEATER_CURRENT_TWO,
  output var  heater_alarm_pkg::current_t LEAKAGE_CURRENT_ONE,
  output var  heater_alarm_pkg::current_t LEAKAGE_CURRENT_TWO,
  // Alarms
  output var  logic [1:0]            HEATER_OPEN_ALARM,
  output var  logic [1:0]            HEATER_SHORT_ALARM,
  output var  logic [1:0]            HEATER_OVERCURRENT_ALARM,
  output var  logic                  FIRST_ALARM_OUTPUT
);
  // ==========================================================
  // Phase tracking
  heater_alarm_pkg::phase_t              phase_r;
  heater_alarm_pkg::phase_t              phase_nxt;
  logic [`PHASE_CNT_W-1:0]               cnt_r;
  logic [`PHASE_CNT_W-1:0]               cnt_nxt;
  logic                                  heat_d_r;
  logic                                  heat_edge;
  logic                                  long_enough;
  logic                                  leave_on;
  logic                                  leave_off;
  logic                                  end_on;
  logic                                  end_off;

  // ==========================================================
  // Helpers
  // Saturating step; a stuck output must not wrap and look short
  function automatic logic [`PHASE_CNT_W-1:0] sat_step(input logic [`PHASE_CNT_W-1:0] c);
    if (&c) begin
      sat_step = c;
    end else begin
      sat_step = c + `PHASE_CNT_W'(1);
    end
  endfunction

  // Strictly longer than the minimum; exactly 100 ms is still skipped
  function automatic logic past_minimum(input logic [`PHASE_CNT_W-1:0] c);
    past_minimum = c > `PHASE_CNT_W'(`MIN_PHASE_CYC);
  endfunction

  // ==========================================================
  // Interval boundaries
  // Only the heating output defines intervals
  assign heat_edge   = HEAT_CTRL != heat_d_r;
  assign long_enough = past_minimum(cnt_r);
  assign leave_on    = (phase_r == heater_alarm_pkg::PH_ON) && !HEAT_CTRL; // [RQ3]
  assign leave_off   = (phase_r == heater_alarm_pkg::PH_OFF) && HEAT_CTRL;
  assign end_on      = leave_on && long_enough;  // [RQ7]
  assign end_off     = leave_off && long_enough; // [RQ8]

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      heater_alarm_pkg::PH_IDLE: begin
        if (HEAT_CTRL) begin
          phase_nxt = heater_alarm_pkg::PH_ON;
        end else begin
          phase_nxt = heater_alarm_pkg::PH_OFF;
        end
      end
      heater_alarm_pkg::PH_ON: begin
        if (!HEAT_CTRL) begin
          phase_nxt = heater_alarm_pkg::PH_OFF;
        end
      end
      heater_alarm_pkg::PH_OFF: begin
        if (HEAT_CTRL) begin
          phase_nxt = heater_alarm_pkg::PH_ON;
        end
      end
      default: begin
        phase_nxt = heater_alarm_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      phase_r <= heater_alarm_pkg::PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      heat_d_r <= 1'b0;
    end else begin
      heat_d_r <= HEAT_CTRL;
    end
  end

  // Fresh interval restarts the length count
  always_comb begin
    if (heat_edge) begin
      cnt_nxt = `PHASE_CNT_W'(1);
    end else begin
      cnt_nxt = sat_step(cnt_r);
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Sense sampling
  // Last sample inside the interval, taken before the edge
  heater_alarm_pkg::current_t            samp_one_r;
  heater_alarm_pkg::current_t            samp_two_r;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      samp_one_r <= 16'h0000;
    end else begin
      samp_one_r <= CURRENT_SENSE_ONE; // [RQ1] [RQ2]
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      samp_two_r <= 16'h0000;
    end else begin
      samp_two_r <= CURRENT_SENSE_TWO; // [RQ1] [RQ2]
    end
  end

  // ==========================================================
  // Monitors
  // Monitors reload on every interval end, short or long
  logic                                  load_heat;
  logic                                  load_leak;

  assign load_heat = leave_on;
  assign load_leak = leave_off;

  current_monitor u_heat_mon_one (
    .clk    (CLOCK),
    .nrst   (NRST),
    .load   (load_heat),
    .sample (samp_one_r),
    .value  (HEATER_CURRENT_ONE)
  ); // [RQ15]

  current_monitor u_heat_mon_two (
    .clk    (CLOCK),
    .nrst   (NRST),
    .load   (load_heat),
    .sample (samp_two_r),
    .value  (HEATER_CURRENT_TWO)
  ); // [RQ15] [RQ16]

  current_monitor u_leak_mon_one (
    .clk    (CLOCK),
    .nrst   (NRST),
    .load   (load_leak),
    .sample (samp_one_r),
    .value  (LEAKAGE_CURRENT_ONE)
  ); // [RQ15]

  current_monitor u_leak_mon_two (
    .clk    (CLOCK),
    .nrst   (NRST),
    .load   (load_leak),
    .sample (samp_two_r),
    .value  (LEAKAGE_CURRENT_TWO)
  ); // [RQ15] [RQ16]

  // ==========================================================
  // Alarms, channels judged independently
  logic                                  open_one;
  logic                                  open_two;
  logic                                  short_one;
  logic                                  short_two;
  logic                                  over_one;
  logic                                  over_two;

  // Missing heater power reads near zero and trips these
  alarm_judge u_open_one (
    .clk       (CLOCK),
    .nrst      (NRST),
    .eval      (end_on),
    .is_open   (1'b1),
    .sample    (samp_one_r),
    .threshold (OPEN_THR_ONE),
    .alarm     (open_one)
  ); // [RQ4] [RQ17]

  alarm_judge u_open_two (
    .clk       (CLOCK),
    .nrst      (NRST),
    .eval      (end_on),
    .is_open   (1'b1),
    .sample    (samp_two_r),
    .threshold (OPEN_THR_TWO),
    .alarm     (open_two)
  ); // [RQ4] [RQ16]

  alarm_judge u_short_one (
    .clk       (CLOCK),
    .nrst      (NRST),
    .eval      (end_off),
    .is_open   (1'b0),
    .sample    (samp_one_r),
    .threshold (SHORT_THR_ONE),
    .alarm     (short_one)
  ); // [RQ5]

  alarm_judge u_short_two (
    .clk       (CLOCK),
    .nrst      (NRST),
    .eval      (end_off),
    .is_open   (1'b0),
    .sample    (samp_two_r),
    .threshold (SHORT_THR_TWO),
    .alarm     (short_two)
  ); // [RQ5] [RQ16]

  alarm_judge u_over_one (
    .clk       (CLOCK),
    .nrst      (NRST),
    .eval      (end_on),
    .is_open   (1'b0),
    .sample    (samp_one_r),
    .threshold (OVER_THR_ONE),
    .alarm     (over_one)
  ); // [RQ6]

  alarm_judge u_over_two (
    .clk       (CLOCK),
    .nrst      (NRST),
    .eval      (end_on),
    .is_open   (1'b0),
    .sample    (samp_two_r),
    .threshold (OVER_THR_TWO),
    .alarm     (over_two)
  ); // [RQ6] [RQ16]

  assign HEATER_OPEN_ALARM        = {open_two, open_one};
  assign HEATER_SHORT_ALARM       = {short_two, short_one};
  assign HEATER_OVERCURRENT_ALARM = {over_two, over_one};

  // ==========================================================
  // Outputs
  // Control passes straight through; alarms never gate it
  assign SOLID_STATE_SWITCH = HEAT_CTRL; // [RQ10]
  assign COOL_OUT           = COOL_CTRL; // [RQ3]

  logic                                  open_any;
  logic                                  short_any;
  logic                                  over_any;
  logic                                  heater_any;
  logic                                  first_nxt;

  assign open_any   = open_one | open_two;
  assign short_any  = short_one | short_two;
  assign over_any   = over_one | over_two;
  assign heater_any = open_any | short_any | over_any;
  // Base alarm tied low leaves only the heater alarms here
  assign first_nxt  = BASE_ALARM | heater_any; // [RQ9]

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      FIRST_ALARM_OUTPUT <= 1'b0;
    end else begin
      FIRST_ALARM_OUTPUT <= first_nxt; // [RQ9]
    end
  end
endmodule // heater_current_alarm_monitor
`default_nettype wire

// File: verilog/heater_alarm_params.svh
// Constants for the heater current alarm monitor
`ifndef HEATER_ALARM_PARAMS_SVH
`define HEATER_ALARM_PARAMS_SVH
// ==========================================================
// Current coding: tenths of an ampere, 16 bits
`define CUR_W            16
`define THR_FORCE_LOW    16'h0000
`define THR_FORCE_HIGH   16'h01F4
`define CUR_OVERFLOW_LIM 16'h0226
`define CUR_OVERFLOW     16'hFFFF
// ==========================================================
// Timing
`define CLK_FREQ_HZ      25000000
`define MIN_PHASE_MS     100
`define MIN_PHASE_CYC    ((`CLK_FREQ_HZ / 1000) * `MIN_PHASE_MS)
`define PHASE_CNT_W      24
`endif

// File: verilog/heater_alarm_pkg.sv
// Types for the heater current alarm monitor
package heater_alarm_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ON   = 2'b01,
    PH_OFF  = 2'b10
  } phase_t;
  typedef logic [15:0] current_t;
endpackage

// File: verilog/current_monitor.sv
// Overflow-coded current monitor register
`timescale 1ns/10ps
`default_nettype none
`include "heater_alarm_params.svh"
module current_monitor (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Sample
  input  wire logic                  load,
  input  wire heater_alarm_pkg::current_t sample,
  // Monitor
  output var  heater_alarm_pkg::current_t value
);
  // ==========================================================
  // Monitor value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value <= 16'h0000;
    end else if (load) begin
      value <= (sample > `CUR_OVERFLOW_LIM) ? `CUR_OVERFLOW : sample; // [RQ14]
    end
  end
endmodule // current_monitor
`default_nettype wire

// File: verilog/alarm_judge.sv
// Threshold comparison for one alarm with forcing codes
`timescale 1ns/10ps
`default_nettype none
`include "heater_alarm_params.svh"
module alarm_judge (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Evaluation
  input  wire logic                  eval,
  input  wire logic                  is_open,
  input  wire heater_alarm_pkg::current_t sample,
  input  wire heater_alarm_pkg::current_t threshold,
  // Result
  output var  logic                  alarm
);
  // ==========================================================
  // Verdict
  function automatic logic judge(input logic op, input logic [15:0] s, input logic [15:0] t);
    if (t == `THR_FORCE_LOW)
      judge = !op;                                    // [RQ12]
    else if (t >= `THR_FORCE_HIGH)
      judge = op;                                     // [RQ13]
    else if (op)
      judge = s < t;                                  // [RQ4]
    else
      judge = s > t;                                  // [RQ5] [RQ6]
  endfunction

  // Forced codes take effect at once; measured verdicts hold between intervals
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm <= 1'b0;
    end else if (eval || threshold == `THR_FORCE_LOW || threshold >= `THR_FORCE_HIGH) begin
      alarm <= judge(is_open, sample, threshold); // [RQ18] [RQ11]
    end
  end
endmodule // alarm_judge
`default_nettype wire

// File: verification/ct_model.sv
// Current transformer model on one heater load line
`timescale 1ns/10ps
`default_nettype none
module ct_model (
  // Switch state
  input  wire logic        sw,
  // Currents the load line carries
  input  wire logic [15:0] on_cur,
  input  wire logic [15:0] leak_cur,
  // Sensed current
  output var  logic [15:0] sense
);
  // ==========
  // Load current while switched on, only leakage while off
  assign sense = sw ? on_cur : leak_cur;
endmodule // ct_model
`default_nettype wire

// File: verification/heater_current_alarm_monitor_asserts.sv
// Assertion checker for the heater current alarm monitor
`timescale 1ns/10ps
`default_nettype none
`include "heater_alarm_params.svh"
module hcam_asserts (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        NRST,
  // Control and thresholds
  input wire logic        HEAT_CTRL,
  input wire logic        SOLID_STATE_SWITCH,
  input wire logic [15:0] OPEN_THR_ONE,
  input wire logic [15:0] SHORT_THR_ONE,
  input wire logic [15:0] OVER_THR_TWO,
  input wire logic        BASE_ALARM,
  // Alarms
  input wire logic [1:0]  HEATER_OPEN_ALARM,
  input wire logic [1:0]  HEATER_SHORT_ALARM,
  input wire logic [1:0]  HEATER_OVERCURRENT_ALARM,
  input wire logic        FIRST_ALARM_OUTPUT
);
  // ==========
  // Long interval marker, generous so the boundary is never judged
  logic        heat_r;
  logic [23:0] run_r;
  logic [3:0]  long_r;
  wire         any_w = BASE_ALARM | (|HEATER_OPEN_ALARM) | (|HEATER_SHORT_ALARM)
                       | (|HEATER_OVERCURRENT_ALARM);
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      heat_r <= 1'h0;
      run_r  <= 24'h00_0000;
      long_r <= 4'h0;
    end else begin
      heat_r <= HEAT_CTRL;
      run_r  <= (HEAT_CTRL != heat_r) ? 24'h00_0000 : run_r + 24'h00_0001;
      long_r <= {long_r[2:0], (HEAT_CTRL != heat_r) && (run_r > `MIN_PHASE_CYC - 8)};
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // ==========
  // Properties
  a_heat_pass: assert property (SOLID_STATE_SWITCH == HEAT_CTRL)
    else $error("switch output differs from heating control");
  a_first_or: assert property ($past(NRST) |-> FIRST_ALARM_OUTPUT == $past(any_w))
    else $error("first alarm output is not the delayed alarm OR");
  a_open_hold: assert property ($past(NRST) && $past(OPEN_THR_ONE) != 16'h0000
    && $past(OPEN_THR_ONE) < 16'h01F4 && long_r == 4'h0 |-> $stable(HEATER_OPEN_ALARM[0]))
    else $error("open alarm changed without a long interval");
  a_open_lo: assert property ($past(NRST) && $past(OPEN_THR_ONE) == 16'h0000
    |-> !HEATER_OPEN_ALARM[0]) else $error("open alarm not held off");
  a_open_hi: assert property ($past(NRST) && $past(OPEN_THR_ONE) >= 16'h01F4
    |-> HEATER_OPEN_ALARM[0]) else $error("open alarm not held on");
  a_short_lo: assert property ($past(NRST) && $past(SHORT_THR_ONE) == 16'h0000
    |-> HEATER_SHORT_ALARM[0]) else $error("short alarm not held on");
  a_over_lo: assert property ($past(NRST) && $past(OVER_THR_TWO) == 16'h0000
    |-> HEATER_OVERCURRENT_ALARM[1]) else $error("overcurrent alarm not held on");
  a_over_hi: assert property ($past(NRST) && $past(OVER_THR_TWO) >= 16'h01F4
    |-> !HEATER_OVERCURRENT_ALARM[1]) else $error("overcurrent alarm not held off");
  c_first: cover property ($rose(FIRST_ALARM_OUTPUT));
  c_heat_end: cover property ($fell(HEAT_CTRL));
  c_split: cover property (HEATER_OPEN_ALARM == 2'h2);
endmodule // hcam_asserts
bind heater_current_alarm_monitor hcam_asserts chk_u (.CLOCK, .NRST, .HEAT_CTRL,
  .SOLID_STATE_SWITCH, .OPEN_THR_ONE, .SHORT_THR_ONE, .OVER_THR_TWO, .BASE_ALARM,
  .HEATER_OPEN_ALARM, .HEATER_SHORT_ALARM, .HEATER_OVERCURRENT_ALARM, .FIRST_ALARM_OUTPUT);
`default_nettype wire

// File: verification/heater_current_alarm_monitor_tb.sv
// Self-checking testbench for the heater current alarm monitor
`timescale 1ns/10ps
`default_nettype none
module heater_current_alarm_monitor_tb;
  // ==========
  // Stimulus and observed outputs
  logic clk = 1'h0, nrst = 1'h0, heat = 1'h0, cool = 1'h0, base = 1'h0;
  logic [15:0] ot1 = 16'h0064, ot2 = 16'h0064, st1 = 16'h0064, st2 = 16'h0064;
  logic [15:0] vt1 = 16'h0064, vt2 = 16'h0064, on1 = 16'h0000, lk1 = 16'h0000;
  logic [15:0] on2 = 16'h0000, lk2 = 16'h0000, s1, s2, hc1, hc2, lc1, lc2;
  logic ssw, cout, fao;
  logic [1:0] oa, sa, va;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  always #20 clk = ~clk;
  heater_current_alarm_monitor dut_u (.CLOCK(clk), .NRST(nrst), .HEAT_CTRL(heat),
    .COOL_CTRL(cool), .SOLID_STATE_SWITCH(ssw), .COOL_OUT(cout),
    .CURRENT_SENSE_ONE(s1), .CURRENT_SENSE_TWO(s2), .OPEN_THR_ONE(ot1),
    .OPEN_THR_TWO(ot2), .SHORT_THR_ONE(st1), .SHORT_THR_TWO(st2), .OVER_THR_ONE(vt1),
    .OVER_THR_TWO(vt2), .BASE_ALARM(base), .HEATER_CURRENT_ONE(hc1),
    .HEATER_CURRENT_TWO(hc2), .LEAKAGE_CURRENT_ONE(lc1), .LEAKAGE_CURRENT_TWO(lc2),
    .HEATER_OPEN_ALARM(oa), .HEATER_SHORT_ALARM(sa), .HEATER_OVERCURRENT_ALARM(va),
    .FIRST_ALARM_OUTPUT(fao));
  ct_model ct1_u (.sw(ssw), .on_cur(on1), .leak_cur(lk1), .sense(s1));
  ct_model ct2_u (.sw(ssw), .on_cur(on2), .leak_cur(lk2), .sense(s2));
  // ==========
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end
  // ==========
  // Scenarios
  task automatic t_base;
    @(posedge clk) base <= 1'h1;
    tick(3);
    chk("first_alarm", 16'(fao), 16'h0001);
    @(posedge clk) base <= 1'h0;
    tick(3);
    chk("first_alarm", 16'(fao), 16'h0000);
  endtask
  task automatic t_pass;
    @(posedge clk) heat <= 1'h1;
    tick(1);
    chk("switch", 16'(ssw), 16'h0001);
    @(posedge clk) begin
      heat <= 1'h0;
      cool <= 1'h1;
    end
    tick(1);
    chk("switch", 16'(ssw), 16'h0000);
    chk("cool_out", 16'(cout), 16'h0001);
  endtask
  task automatic t_force(input logic [15:0] v, input logic [1:0] eo, input logic [1:0] es);
    @(posedge clk) begin
      {ot1, ot2, st1, st2, vt1, vt2} <= {6{v}};
    end
    tick(3);
    chk("open", 16'(oa), 16'(eo));
    chk("short", 16'(sa), 16'(es));
    chk("over", 16'(va), 16'(es));
    chk("first_alarm", 16'(fao), 16'h0001);
  endtask
  task automatic t_indep;
    @(posedge clk) ot1 <= 16'h0000;
    tick(3);
    chk("open", 16'(oa), 16'h0002);
  endtask
  // Currents that would flip every alarm, but intervals stay short
  task automatic t_skip;
    @(posedge clk) begin
      {ot1, ot2, st1, st2, vt1, vt2} <= {16'h01F3, {5{16'h0001}}};
      {on1, lk1, on2, lk2} <= {4{16'h0190}};
    end
    repeat (6) begin
      repeat (200) @(posedge clk);
      heat <= ~heat;
    end
    tick(5);
    chk("open", 16'(oa), 16'h0002);
    chk("short", 16'(sa), 16'h0000);
    chk("over", 16'(va), 16'h0000);
  endtask
  task automatic t_mon;
    @(posedge clk) {on1, lk1, on2, lk2} <= {16'h0258, 16'h0032, 16'h0226, 16'h0227};
    repeat (10) @(posedge clk);
    heat <= 1'h1;
    repeat (10) @(posedge clk);
    heat <= 1'h0;
    tick(4);
    chk("heater_one", hc1, 16'hFFFF);
    chk("heater_two", hc2, 16'h0226);
    chk("leak_one", lc1, 16'h0032);
    repeat (10) @(posedge clk);
    heat <= 1'h1;
    tick(4);
    chk("leak_two", lc2, 16'hFFFF);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    tick(2);
    t_base;
    t_pass;
    t_force(16'h0000, 2'h0, 2'h3);
    t_force(16'h01F4, 2'h3, 2'h0);
    t_indep;
    t_skip;
    t_mon;
    close_out;
  end
endmodule // heater_current_alarm_monitor_tb
`default_nettype wire
